// ### rtl/iop_pkg.sv
package iop_pkg;

    // Bus geometry
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned IDX_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_PORT0 = 6'h00;
    localparam logic [5:0] IDX_PORT1 = 6'h01;
    localparam logic [5:0] IDX_PORT2_DIR = 6'h02;
    localparam logic [5:0] IDX_PORT2 = 6'h03;
    localparam logic [5:0] IDX_PORT3 = 6'h04;
    localparam logic [5:0] IDX_PORT4 = 6'h05;
    localparam logic [5:0] IDX_SYNC_CTRL = 6'h07;
    localparam logic [5:0] IDX_FREE_RUN = 6'h0c;
    localparam logic [5:0] IDX_PWM_EN = 6'h0f;
    localparam logic [5:0] IDX_ADC_EN = 6'h10;
    localparam logic [5:0] IDX_NMI_EN = 6'h18;
    localparam logic [5:0] IDX_IRQ2_EN = 6'h1b;
    localparam logic [5:0] IDX_SER0_CTRL = 6'h28;
    localparam logic [5:0] IDX_SER1_CTRL = 6'h29;
    localparam logic [5:0] IDX_OUT_FUNC = 6'h30;

    // Reset values
    localparam logic [7:0] RST_PORT0 = 8'hff;
    localparam logic [6:0] RST_PORT1 = 7'h7f;
    localparam logic [7:0] RST_PORT2_DIR = 8'hff;
    localparam logic [7:0] RST_PORT2 = 8'hff;
    localparam logic [1:0] RST_PORT3 = 2'h3;
    localparam logic [1:0] RST_PORT4 = 2'h3;
    localparam logic [1:0] RST_SYNC_EN = 2'h3;
    localparam logic [1:0] RST_SYNC_POL = 2'h3;
    localparam logic [7:0] RST_FREE_RUN = 8'hff;
    localparam logic [5:0] RST_PWM_EN = 6'h3f;
    localparam logic [7:0] RST_ADC_EN = 8'hff;
    localparam logic [7:0] RST_NMI_EN = 8'h00;
    localparam logic [7:0] RST_IRQ2_EN = 8'h00;
    localparam logic [7:0] RST_SER_CTRL = 8'hff;
    localparam logic [7:0] RST_OUT_FUNC = 8'hff;

    // Field positions
    localparam int unsigned SYNC_HOUT_SEL_BIT = 7;
    localparam int unsigned SYNC_VOUT_SEL_BIT = 6;
    localparam int unsigned SYNC_HIN_BIT = 5;
    localparam int unsigned SYNC_VIN_BIT = 4;
    localparam int unsigned SYNC_HORIZONTAL_INPUT_POLARITY_BIT = 3;
    localparam int unsigned SYNC_VERTICAL_INPUT_POLARITY_BIT = 2;
    localparam int unsigned FREE_PAT_BIT = 7;
    localparam logic [2:0] FREE_FREQ_OFF = 3'h7;
    localparam int unsigned NMI_EXT0_BIT = 1;
    localparam int unsigned IRQ2_EXT1_BIT = 1;
    localparam int unsigned SER_SEL_BIT = 7;
    localparam int unsigned OUT_HALF_BIT = 0;

    // Port widths
    localparam int unsigned PORT1_W = 7;
    localparam int unsigned PWM_PINS = 6;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : iop_pkg

// ### rtl/iop_ports.sv
// Functional notes
// RULE1 - Port0 quasi-bidirectional: latch drives, ones pulled up
// RULE2 - Port0 data resets to all ones
// RULE3 - Port0 pins 0-5 become PWM when enable low
// RULE4 - Port0 pins 6,7 become sync outputs when low
// RULE5 - Port1 seven-bit quasi port, resets all high
// RULE6 - Port1 pins 0,1 become analog inputs when cleared
// RULE7 - Half-frequency select low: pin3 input, pin2 output
// RULE8 - Pattern output on pin4 when cleared and free-running
// RULE9 - Pins 5,6 feed external interrupts when enabled
// RULE10 - Port2 direction zero outputs latch, one inputs
// RULE11 - Port2 direction and data reset to ones
// RULE12 - Port3 two-bit open-drain, released after reset
// RULE13 - Serial0 select low routes port3 to SDA/SCL
// RULE14 - Port4 two-bit quasi port, outputs high at reset
// RULE15 - Sync register reads live levels and polarities
// RULE16 - Data latches keep value while pins borrowed
//
// Added by the designer: the AXI4-Lite slave port.
module iop_ports
    import iop_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Port0 pins
    input wire logic [7:0] p0In,
    output logic [7:0] p0Out,
    output logic [7:0] p0Oe,
    output logic [7:0] p0PullUp,
    // Port1 pins
    input wire logic [PORT1_W-1:0] p1In,
    output logic [PORT1_W-1:0] p1Out,
    output logic [PORT1_W-1:0] p1Oe,
    output logic [PORT1_W-1:0] p1PullUp,
    // Port2 pins
    input wire logic [7:0] p2In,
    output logic [7:0] p2Out,
    output logic [7:0] p2Oe,
    output logic [7:0] p2PullUp,
    // Port3 open-drain pins
    input wire logic [1:0] p3In,
    output logic [1:0] p3Out,
    output logic [1:0] p3Oe,
    // Port4 pins
    input wire logic [1:0] p4In,
    output logic [1:0] p4Out,
    output logic [1:0] p4Oe,
    output logic [1:0] p4PullUp,
    // Alternate function sources
    input wire logic [PWM_PINS-1:0] pwmOut,
    input wire logic vsyncOut,
    input wire logic hsyncOut,
    input wire logic halfFreqOut,
    input wire logic patternOut,
    input wire logic serial0DataLow,
    input wire logic serial0ClockLow,
    // Sync processor status
    input wire logic hsyncInLevel,
    input wire logic vsyncInLevel,
    input wire logic hsyncInPol,
    input wire logic vsyncInPol,
    // Alternate function sinks and controls
    output logic [1:0] analogInSel,
    output logic halfFreqIn,
    output logic [1:0] extIntLevel,
    output logic serial0DataIn,
    output logic serial0ClockIn,
    output logic hsyncOutPol,
    output logic vsyncOutPol,
    output logic hsyncOutSel,
    output logic vsyncOutSel,
    output logic [2:0] freeRunFreq,
    output logic patternActive,
    output logic [7:0] adcEnable,
    output logic [7:0] nmiEnable,
    output logic [7:0] irq2Enable,
    output logic [7:0] serial1Control
);

    // Register state
    logic [7:0] port0Q;
    logic [PORT1_W-1:0] port1Q;
    logic [7:0] port2DirQ;
    logic [7:0] port2Q;
    logic [1:0] port3Q;
    logic [1:0] port4Q;
    logic [1:0] syncSelQ;
    logic [1:0] syncPolQ;
    logic [7:0] freeRunQ;
    logic [PWM_PINS-1:0] pwmEnQ;
    logic [7:0] adcEnQ;
    logic [7:0] nmiEnQ;
    logic [7:0] irq2EnQ;
    logic [7:0] ser0Q;
    logic [7:0] ser1Q;
    logic [7:0] outFuncQ;

    // Bus channel state
    logic awHeldQ;
    logic wHeldQ;
    logic [IDX_W-1:0] wrIdxQ;
    logic [7:0] wrDataQ;
    logic wrStrbQ;
    logic bvalidQ;
    logic [1:0] brespQ;
    logic rvalidQ;
    logic [31:0] rdataQ;
    logic [1:0] rrespQ;
    logic wrDo;
    logic wrEn;

    function automatic logic isMapped(input logic [IDX_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        if (idx == IDX_PORT0) begin
            hit = 1'b1;
        end else if (idx == IDX_PORT1 || idx == IDX_PORT2_DIR || idx == IDX_PORT2) begin
            hit = 1'b1;
        end else if (idx == IDX_PORT3 || idx == IDX_PORT4 || idx == IDX_SYNC_CTRL) begin
            hit = 1'b1;
        end else if (idx == IDX_FREE_RUN || idx == IDX_PWM_EN || idx == IDX_ADC_EN) begin
            hit = 1'b1;
        end else if (idx == IDX_NMI_EN || idx == IDX_IRQ2_EN || idx == IDX_SER0_CTRL) begin
            hit = 1'b1;
        end else if (idx == IDX_SER1_CTRL || idx == IDX_OUT_FUNC) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : isMapped

    // Write address and data taken in either order, one write in flight
    assign awready = !awHeldQ && !bvalidQ;
    assign wready = !wHeldQ && !bvalidQ;
    assign wrDo = awHeldQ && wHeldQ;
    assign wrEn = wrDo && wrStrbQ && isMapped(wrIdxQ);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            wrIdxQ <= '0;
            wrDataQ <= 8'h00;
            wrStrbQ <= 1'b0;
            bvalidQ <= 1'b0;
            brespQ <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeldQ <= 1'b1;
                wrIdxQ <= awaddr[AXI_ADDR_W-1:2];
            end
            if (wvalid && wready) begin
                wHeldQ <= 1'b1;
                wrDataQ <= wdata[7:0];
                wrStrbQ <= wstrb[0];
            end
            if (wrDo) begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                bvalidQ <= 1'b1;
                brespQ <= isMapped(wrIdxQ) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalidQ && bready) begin
                bvalidQ <= 1'b0;
            end
        end
    end

    assign bvalid = bvalidQ;
    assign bresp = brespQ;

    // Latches change only on their own write, never on mode changes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port0Q <= RST_PORT0; // RULE2
            port1Q <= RST_PORT1; // RULE5
            port2DirQ <= RST_PORT2_DIR; // RULE11
            port2Q <= RST_PORT2; // RULE11
            port3Q <= RST_PORT3; // RULE12
            port4Q <= RST_PORT4; // RULE14
            syncSelQ <= RST_SYNC_EN;
            syncPolQ <= RST_SYNC_POL;
            freeRunQ <= RST_FREE_RUN;
            pwmEnQ <= RST_PWM_EN;
            adcEnQ <= RST_ADC_EN;
            nmiEnQ <= RST_NMI_EN;
            irq2EnQ <= RST_IRQ2_EN;
            ser0Q <= RST_SER_CTRL;
            ser1Q <= RST_SER_CTRL;
            outFuncQ <= RST_OUT_FUNC;
        end else if (wrEn) begin
            if (wrIdxQ == IDX_PORT0) begin
                port0Q <= wrDataQ;
            end else if (wrIdxQ == IDX_PORT1) begin
                port1Q <= wrDataQ[PORT1_W-1:0];
            end else if (wrIdxQ == IDX_PORT2_DIR) begin
                port2DirQ <= wrDataQ;
            end else if (wrIdxQ == IDX_PORT2) begin
                port2Q <= wrDataQ;
            end else if (wrIdxQ == IDX_PORT3) begin
                port3Q <= wrDataQ[1:0];
            end else if (wrIdxQ == IDX_PORT4) begin
                port4Q <= wrDataQ[1:0];
            end else if (wrIdxQ == IDX_SYNC_CTRL) begin
                syncSelQ <= wrDataQ[SYNC_HOUT_SEL_BIT:SYNC_VOUT_SEL_BIT];
                syncPolQ <= wrDataQ[1:0]; // RULE15
            end else if (wrIdxQ == IDX_FREE_RUN) begin
                freeRunQ <= wrDataQ;
            end else if (wrIdxQ == IDX_PWM_EN) begin
                pwmEnQ <= wrDataQ[PWM_PINS-1:0];
            end else if (wrIdxQ == IDX_ADC_EN) begin
                adcEnQ <= wrDataQ;
            end else if (wrIdxQ == IDX_NMI_EN) begin
                nmiEnQ <= wrDataQ;
            end else if (wrIdxQ == IDX_IRQ2_EN) begin
                irq2EnQ <= wrDataQ;
            end else if (wrIdxQ == IDX_SER0_CTRL) begin
                ser0Q <= wrDataQ;
            end else if (wrIdxQ == IDX_SER1_CTRL) begin
                ser1Q <= wrDataQ;
            end else if (wrIdxQ == IDX_OUT_FUNC) begin
                outFuncQ <= wrDataQ;
            end
        end
    end

    // Read side: port registers return pin levels, write-only ones zero
    function automatic logic [7:0] readMux(input logic [IDX_W-1:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx == IDX_PORT0) begin
            val = p0In;
        end else if (idx == IDX_PORT1) begin
            val = {1'b0, p1In};
        end else if (idx == IDX_PORT2) begin
            val = p2In;
        end else if (idx == IDX_PORT3) begin
            val = {6'h00, p3In};
        end else if (idx == IDX_PORT4) begin
            val = {6'h00, p4In};
        end else if (idx == IDX_SYNC_CTRL) begin
            val = {2'b00, hsyncInLevel, vsyncInLevel, hsyncInPol, vsyncInPol, syncPolQ}; // RULE15
        end else if (idx == IDX_NMI_EN) begin
            val = nmiEnQ;
        end else if (idx == IDX_IRQ2_EN) begin
            val = irq2EnQ;
        end else if (idx == IDX_SER1_CTRL) begin
            val = ser1Q;
        end else if (idx == IDX_SER0_CTRL) begin
            val = ser0Q;
        end else if (idx == IDX_OUT_FUNC) begin
            val = outFuncQ;
        end
        return val;
    endfunction : readMux

    assign arready = !rvalidQ;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalidQ <= 1'b0;
            rdataQ <= 32'h0000_0000;
            rrespQ <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalidQ <= 1'b1;
            rdataQ <= {24'h00_0000, readMux(araddr[AXI_ADDR_W-1:2])};
            rrespQ <= isMapped(araddr[AXI_ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalidQ && rready) begin
            rvalidQ <= 1'b0;
        end
    end

    assign rvalid = rvalidQ;
    assign rdata = rdataQ;
    assign rresp = rrespQ;

    // Pin selections
    logic halfSel;
    logic patSel;
    logic ser0Sel;
    assign halfSel = !outFuncQ[OUT_HALF_BIT];
    assign patSel = !freeRunQ[FREE_PAT_BIT] && (freeRunQ[2:0] != FREE_FREQ_OFF); // RULE8
    assign ser0Sel = !ser0Q[SER_SEL_BIT];

    // Port0: quasi pins, with PWM and sync borrowing
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_port0
            logic altOn;
            logic altVal;
            if (gi < PWM_PINS) begin : g_pwm
                assign altOn = !pwmEnQ[gi]; // RULE3
                assign altVal = pwmOut[gi];
            end else if (gi == 6) begin : g_vsync
                assign altOn = !syncSelQ[0]; // RULE4
                assign altVal = vsyncOut;
            end else begin : g_hsync
                assign altOn = !syncSelQ[1]; // RULE4
                assign altVal = hsyncOut;
            end
            assign p0Out[gi] = altOn ? altVal : 1'b0;
            assign p0Oe[gi] = altOn ? 1'b1 : !port0Q[gi]; // RULE1
            assign p0PullUp[gi] = altOn ? 1'b0 : port0Q[gi]; // RULE1
        end
    endgenerate

    // Port1: analog, half frequency, pattern and interrupt borrowing
    logic [PORT1_W-1:0] p1Alt;
    logic [PORT1_W-1:0] p1AltDrive;
    logic [PORT1_W-1:0] p1AltVal;
    always_comb begin
        p1Alt = '0;
        p1AltDrive = '0;
        p1AltVal = '0;
        p1Alt[1:0] = ~adcEnQ[1:0]; // RULE6
        p1Alt[2] = halfSel; // RULE7
        p1AltDrive[2] = halfSel;
        p1AltVal[2] = halfFreqOut;
        p1Alt[3] = halfSel; // RULE7
        p1Alt[4] = patSel; // RULE8
        p1AltDrive[4] = patSel;
        p1AltVal[4] = patternOut;
        p1Alt[5] = nmiEnQ[NMI_EXT0_BIT]; // RULE9
        p1Alt[6] = irq2EnQ[IRQ2_EXT1_BIT]; // RULE9
    end

    // Input-only alternates float: no drive, no pull-up
    assign p1Out = p1AltVal & p1AltDrive;
    assign p1Oe = (p1Alt & p1AltDrive) | (~p1Alt & ~port1Q); // RULE5
    assign p1PullUp = ~p1Alt & port1Q; // RULE5
    assign analogInSel = ~adcEnQ[1:0];
    assign halfFreqIn = halfSel & p1In[3];
    assign extIntLevel = p1Alt[6:5] & p1In[6:5];

    // Port2: push-pull output where direction is zero
    assign p2Oe = ~port2DirQ; // RULE10
    assign p2Out = port2Q & ~port2DirQ; // RULE10
    assign p2PullUp = port2DirQ; // RULE10

    // Port3: only ever pulls low; board pull-ups make the high level
    assign p3Out = 2'b00; // RULE12
    assign p3Oe = ser0Sel ? {serial0ClockLow, serial0DataLow} : ~port3Q; // RULE13
    assign serial0DataIn = p3In[0];
    assign serial0ClockIn = p3In[1];

    // Port4: quasi pins, no alternates
    assign p4Out = 2'b00;
    assign p4Oe = ~port4Q; // RULE14
    assign p4PullUp = port4Q; // RULE14

    // Controls to neighbouring blocks
    assign hsyncOutPol = syncPolQ[1];
    assign vsyncOutPol = syncPolQ[0];
    assign hsyncOutSel = !syncSelQ[1];
    assign vsyncOutSel = !syncSelQ[0];
    assign freeRunFreq = freeRunQ[2:0];
    assign patternActive = patSel;
    assign adcEnable = adcEnQ;
    assign nmiEnable = nmiEnQ;
    assign irq2Enable = irq2EnQ;
    assign serial1Control = ser1Q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_P0_RESET: assert property ($rose(rst_b) |-> port0Q == RST_PORT0 && p0Oe == 8'h00) // RULE2
        else $error("port0 not released high after reset");
    AST_P0_QUASI: assert property (pwmEnQ[1] |-> p0Oe[1] == !port0Q[1] && !p0Out[1]) // RULE1
        else $error("port0 quasi pin drive wrong");
    AST_PWM_SEL: assert property (!pwmEnQ[0] |-> p0Oe[0] && p0Out[0] == pwmOut[0]) // RULE3
        else $error("pwm not on port0 pin");
    AST_SYNC_SEL: assert property (wrEn && wrIdxQ == IDX_SYNC_CTRL && !wrDataQ[6] // RULE4
        |=> p0Oe[6] && p0Out[6] == vsyncOut)
        else $error("vsync output not selected");
    AST_P1_RESET: assert property ($rose(rst_b) |-> p1PullUp == 7'h7f) // RULE5
        else $error("port1 not high after reset");
    AST_ADC: assert property (!adcEnQ[1] |-> !p1Oe[1] && !p1PullUp[1]) // RULE6
        else $error("analog pin still driven");
    AST_HALF: assert property (halfSel |-> p1Oe[2] && !p1Oe[3] && halfFreqIn == p1In[3]) // RULE7
        else $error("half frequency pins wrong");
    AST_PAT: assert property (freeRunQ[FREE_PAT_BIT] |-> p1Oe[4] == !port1Q[4]) // RULE8
        else $error("pattern output without enable");
    AST_EXT: assert property (nmiEnQ[NMI_EXT0_BIT] // RULE9
        |-> extIntLevel[0] == p1In[5] && !p1Oe[5])
        else $error("external interrupt pin wrong");
    AST_P2_DIR: assert property (wrEn && wrIdxQ == IDX_PORT2_DIR // RULE10
        |=> p2Oe == ~$past(wrDataQ))
        else $error("port2 direction not applied");
    AST_P2_RESET: assert property ($rose(rst_b) |-> p2Oe == 8'h00 && port2Q == RST_PORT2) // RULE11
        else $error("port2 not input after reset");
    AST_P3_OD: assert property (p3Out == 2'b00 and (!ser0Sel |-> p3Oe == ~port3Q)) // RULE12
        else $error("port3 drives high");
    AST_SER: assert property (ser0Sel |-> p3Oe[1] == serial0ClockLow) // RULE13
        else $error("serial clock not routed");
    AST_P4: assert property ($rose(rst_b) |-> p4Oe == 2'b00 ##1 p4PullUp == 2'b11) // RULE14
        else $error("port4 not high after reset");
    AST_SYNC_READ: assert property (arvalid && arready && araddr[AXI_ADDR_W-1:2] == IDX_SYNC_CTRL
        |=> rvalid && rdata[5] == $past(hsyncInLevel) && rdata[2] == $past(vsyncInPol)) // RULE15
        else $error("sync status read wrong");
    AST_HOLD: assert property (!wrEn ##1 !wrEn |-> $stable(port0Q) && $stable(port1Q)) // RULE16
        else $error("data latch changed without write");
    AST_BHOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    COV_PWM: cover property (!pwmEnQ[0] ##1 pwmEnQ[0]);
    COV_SYNC: cover property (hsyncOutSel && vsyncOutSel);
    COV_SER: cover property (ser0Sel && serial0ClockLow);
    COV_PAT: cover property (patSel);

endmodule : iop_ports

// ### tb/iop_board_model.sv
module iop_board_model #(
    parameter int W = 8
) (
    // Clock
    input wire logic clk,
    // Device side of the pins
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pullUp,
    // Board drivers
    input wire logic [W-1:0] extEn,
    input wire logic [W-1:0] extVal,
    output logic [W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [W-1:0] floatQ = '0;

    // Floating pins wander so a missing pull-up cannot pass unseen
    always_ff @(posedge clk) begin
        floatQ <= ~floatQ;
    end

    // Board resistors count as pullUp for open-drain pins
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) begin
                pin[i] = out[i];
            end else if (extEn[i]) begin
                pin[i] = extVal[i];
            end else if (pullUp[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = floatQ[i];
            end
        end
    end
endmodule : iop_board_model

// ### tb/tb_io_ports_with_pin_sharing.sv
module tb_io_ports_with_pin_sharing
    import iop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, vsyncOut, hsyncOut, halfFreqOut, patternOut;
    logic serial0DataLow, serial0ClockLow, hsyncInLevel, vsyncInLevel, hsyncInPol, vsyncInPol;
    logic halfFreqIn, serial0DataIn, serial0ClockIn, hsyncOutPol, vsyncOutPol;
    logic hsyncOutSel, vsyncOutSel, patternActive;
    logic [7:0] awaddr, araddr, p0In, p0Out, p0Oe, p0PullUp, p2In, p2Out, p2Oe, p2PullUp;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, p3In, p3Out, p3Oe, p4In, p4Out, p4Oe, p4PullUp;
    logic [1:0] analogInSel, extIntLevel;
    logic [6:0] p1In, p1Out, p1Oe, p1PullUp;
    logic [7:0] adcEnable, nmiEnable, irq2Enable, serial1Control;
    logic [5:0] pwmOut;
    logic [7:0] eEn [5];
    logic [7:0] eVal [5];
    int fails = 0;
    int samplesChecked = 0;

    always #50 clk = ~clk;

    iop_ports dut_u (.clk, .rst_b, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .p0In, .p0Out, .p0Oe, .p0PullUp,
        .p1In, .p1Out, .p1Oe, .p1PullUp, .p2In, .p2Out, .p2Oe, .p2PullUp, .p3In, .p3Out,
        .p3Oe, .p4In, .p4Out, .p4Oe, .p4PullUp, .pwmOut, .vsyncOut, .hsyncOut, .halfFreqOut,
        .patternOut, .serial0DataLow, .serial0ClockLow, .hsyncInLevel, .vsyncInLevel,
        .hsyncInPol, .vsyncInPol, .analogInSel, .halfFreqIn, .extIntLevel, .serial0DataIn,
        .serial0ClockIn, .hsyncOutPol, .vsyncOutPol, .hsyncOutSel, .vsyncOutSel,
        .freeRunFreq(), .patternActive, .adcEnable, .nmiEnable, .irq2Enable,
        .serial1Control);

    iop_board_model #(.W(8)) b0_u (.clk, .oe(p0Oe), .out(p0Out), .pullUp(p0PullUp),
        .extEn(eEn[0]), .extVal(eVal[0]), .pin(p0In));
    iop_board_model #(.W(7)) b1_u (.clk, .oe(p1Oe), .out(p1Out), .pullUp(p1PullUp),
        .extEn(eEn[1][6:0]), .extVal(eVal[1][6:0]), .pin(p1In));
    iop_board_model #(.W(8)) b2_u (.clk, .oe(p2Oe), .out(p2Out), .pullUp(p2PullUp),
        .extEn(eEn[2]), .extVal(eVal[2]), .pin(p2In));
    // Open drain: resistors on the board
    iop_board_model #(.W(2)) b3_u (.clk, .oe(p3Oe), .out(p3Out), .pullUp(2'h3),
        .extEn(eEn[3][1:0]), .extVal(eVal[3][1:0]), .pin(p3In));
    iop_board_model #(.W(2)) b4_u (.clk, .oe(p4Oe), .out(p4Out), .pullUp(p4PullUp),
        .extEn(eEn[4][1:0]), .extVal(eVal[4][1:0]), .pin(p4In));

    function automatic logic [7:0] ba(input logic [5:0] i);
        return {i, 2'b00};
    endfunction : ba

    task automatic close_out;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, er);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata, {24'h0, d});
        chk(rresp, er);
    endtask : axr

    task automatic t_reset;
        @(negedge clk);
        chk({p0Oe, p0PullUp}, 16'h00ff);
        chk({p1Oe, p1PullUp}, 14'h007f);
        chk({p2Oe, p2PullUp, p3Oe}, 18'h003fc);
        chk({serial1Control, p4Oe, p4PullUp}, 12'hff3);
        chk({analogInSel, hsyncOutSel, vsyncOutSel, patternActive, extIntLevel}, 0);
        @(posedge clk);
        axr(ba(IDX_PORT0), 8'hff, RESP_OKAY);
        axr(ba(IDX_SER1_CTRL), 8'hff, RESP_OKAY);
        axw(ba(6'h06), 8'h12, RESP_SLVERR);
        axr(ba(6'h06), 8'h00, RESP_SLVERR);
        axr(ba(IDX_FREE_RUN), 8'h00, RESP_OKAY);
        $display("test reset and map done");
    endtask : t_reset

    task automatic t_quasi;
        axw(ba(IDX_PORT0), 8'ha5, RESP_OKAY);
        axw(ba(IDX_PORT1), 8'h55, RESP_OKAY);
        axw(ba(IDX_PORT4), 8'h01, RESP_OKAY);
        eEn[0] <= 8'h01;
        eVal[0] <= 8'h00;
        @(negedge clk);
        chk({p0Oe, p0Out & p0Oe, p0PullUp}, 24'h5a00a5);
        chk(p1Oe, 7'h2a);
        chk({p4Oe, p4PullUp}, 4'h9);
        @(posedge clk);
        axr(ba(IDX_PORT0), 8'ha4, RESP_OKAY);
        eEn[0] <= 8'h00;
        $display("test quasi ports done");
    endtask : t_quasi

    task automatic t_port2;
        axw(ba(IDX_PORT2_DIR), 8'h00, RESP_OKAY);
        @(negedge clk);
        chk({p2Oe, p2Out}, 16'hffff);
        @(posedge clk);
        axw(ba(IDX_PORT2_DIR), 8'h0f, RESP_OKAY);
        axw(ba(IDX_PORT2), 8'h3c, RESP_OKAY);
        eEn[2] <= 8'h0f;
        eVal[2] <= 8'h05;
        @(negedge clk);
        chk({p2Oe, p2Out, p2PullUp}, 24'hf0300f);
        @(posedge clk);
        axr(ba(IDX_PORT2), 8'h35, RESP_OKAY);
        axr(ba(IDX_PORT2_DIR), 8'h00, RESP_OKAY);
        $display("test port2 done");
    endtask : t_port2

    task automatic t_port0_alt;
        pwmOut <= 6'h2a;
        {vsyncOut, hsyncOut} <= 2'b10;
        {hsyncInLevel, vsyncInLevel, hsyncInPol, vsyncInPol} <= 4'hb;
        axw(ba(IDX_SYNC_CTRL), 8'h3e, RESP_OKAY);
        axw(ba(IDX_PWM_EN), 8'h3e, RESP_OKAY);
        @(negedge clk);
        chk({p0Oe, p0Out[7:6], p0Out[0]}, 11'h6da);
        chk({hsyncOutPol, vsyncOutPol}, 2'b10);
        @(posedge clk);
        axr(ba(IDX_SYNC_CTRL), 8'h2e, RESP_OKAY);
        axw(ba(IDX_PWM_EN), 8'h00, RESP_OKAY);
        @(negedge clk);
        chk({p0Oe, p0Out[5:0], p0PullUp[5:0]}, 20'hffa80);
        @(posedge clk);
        axw(ba(IDX_PWM_EN), 8'h3f, RESP_OKAY);
        axw(ba(IDX_SYNC_CTRL), 8'hff, RESP_OKAY);
        @(negedge clk);
        chk(p0Oe, 8'h5a);
        @(posedge clk);
        $display("test port0 alternates done");
    endtask : t_port0_alt

    task automatic t_port1_alt;
        {halfFreqOut, patternOut} <= 2'b11;
        eEn[1] <= 8'h68;
        eVal[1] <= 8'h48;
        axw(ba(IDX_ADC_EN), 8'hfc, RESP_OKAY);
        axw(ba(IDX_OUT_FUNC), 8'hfe, RESP_OKAY);
        axw(ba(IDX_FREE_RUN), 8'h7f, RESP_OKAY);
        @(negedge clk);
        chk({adcEnable, analogInSel, p1Oe[1:0], p1PullUp[1:0]}, 14'h3f30);
        chk({p1Oe[2], p1Out[2], halfFreqIn}, 3'h7);
        chk({p1Oe[4], extIntLevel}, 3'h0);
        @(posedge clk);
        axw(ba(IDX_FREE_RUN), 8'h78, RESP_OKAY);
        axw(ba(IDX_NMI_EN), 8'h02, RESP_OKAY);
        axw(ba(IDX_IRQ2_EN), 8'h02, RESP_OKAY);
        @(negedge clk);
        chk({p1Oe[4], p1Out[4], extIntLevel, nmiEnable, irq2Enable}, 20'he0202);
        @(posedge clk);
        axr(ba(IDX_NMI_EN), 8'h02, RESP_OKAY);
        $display("test port1 alternates done");
    endtask : t_port1_alt

    task automatic t_port3;
        axw(ba(IDX_PORT3), 8'h02, RESP_OKAY);
        eEn[3] <= 8'h02;
        eVal[3] <= 8'h00;
        @(negedge clk);
        chk({p3Oe, p3Out}, 4'h4);
        @(posedge clk);
        axr(ba(IDX_PORT3), 8'h00, RESP_OKAY);
        eEn[3] <= 8'h00;
        {serial0DataLow, serial0ClockLow} <= 2'b01;
        axw(ba(IDX_SER0_CTRL), 8'h7f, RESP_OKAY);
        @(negedge clk);
        chk({p3Oe, serial0DataIn}, 3'h5);
        @(posedge clk);
        $display("test port3 done");
    endtask : t_port3

    // A hung handshake ends the run as a failure
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out;
    end

    initial begin
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
        {awaddr, araddr, wdata, pwmOut} = '0;
        {vsyncOut, hsyncOut, halfFreqOut, patternOut, serial0DataLow, serial0ClockLow} = '0;
        {hsyncInLevel, vsyncInLevel, hsyncInPol, vsyncInPol} = '0;
        eEn = '{default: 8'h00};
        eVal = '{default: 8'h00};
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_quasi;
        t_port2;
        t_port0_alt;
        t_port1_alt;
        t_port3;
        close_out;
    end
endmodule : tb_io_ports_with_pin_sharing
